/* design/osc_ready_enable_tune_regs.sv */
// Oscillator ready, manual enable, trim and frequency register block on APB.
//
// Register access over APB was decided locally.
`timescale 1ns/1ns

module osc_ready_enable_tune_regs
  import osc_regs_pkg::*;
#(
  parameter int N_REQ = 4
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  input  wire logic [2:0]            reset_source_config,
  input  wire logic [2:0]            requested_source_select,
  input  wire logic [N_REQ*SRC_N-1:0] periph_request,
  input  wire logic [SRC_N-1:0]      source_ready_raw,
  input  wire logic                  lock_ready_raw,
  output logic [SRC_N-1:0]           osc_enable,
  output osc_ctrl_t                  osc_ctrl
);

  ////////////////////////////////////////////////////////////////////////////
  logic [SRC_N-1:0]  force_q, force_d;
  logic [TRIM_W-1:0] trim_q, trim_d;
  logic [FRQ_W-1:0]  frq_q, frq_d;
  logic              pwr_q, pwr_d;
  logic              strap_done_q, strap_done_d;
  logic [SRC_N:0]    sync1_q, sync2_q;
  logic [SRC_N-1:0]  en_q, en_d;
  osc_ctrl_t         ctrl_q, ctrl_d;
  logic              rdy_q, rdy_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              err_q, err_d;
  logic [SRC_N-1:0]  req_or;
  logic [11:0]       idx;
  logic              word_ok;
  logic              access;
  logic              commit;

  ////////////////////////////////////////////////////////////////////////////
  // Ready inputs come from analog clock domains; only stage two is read.
  // ready synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {source_ready_raw, lock_ready_raw};
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign idx     = 12'(paddr[ADDR_W-1:2]);
  assign word_ok = (paddr[1:0] == 2'h0);
  // Slave answers one cycle after the first access cycle; pready is a registered pulse.
  assign access  = psel && penable && !rdy_q;
  // A write lands only at the edge where the master sees pready, so an aborted
  // transfer leaves the registers untouched. Refused accesses never commit.
  assign commit  = psel && penable && rdy_q && pwrite && !err_q && pstrb[0];

  always_comb begin
    req_or = '0;
    for (int i = 0; i < N_REQ; i++) begin
      req_or = req_or | periph_request[i*SRC_N +: SRC_N];
    end
  end

  always_comb begin
    force_d      = force_q;
    trim_d       = trim_q;
    frq_d        = frq_q;
    pwr_d        = pwr_q;
    strap_done_d = 1'b1;
    rdy_d        = access;
    rdata_d      = 32'h0000_0000;
    err_d        = 1'b0;
    if (!strap_done_q) begin
      frq_d = (reset_source_config == SRC_HF_DOUBLED) ? FRQ_RESET_DOUBLED : FRQ_RESET_PLAIN;
    end
    if (access) begin
      if (!word_ok) begin
        err_d = 1'b1;
      end else if (idx == IDX_READY_STATUS) begin
        rdata_d[BIT_SRC_LO +: SRC_N] = sync2_q[SRC_N:1];
        rdata_d[BIT_LOCK] = sync2_q[0];
        err_d = pwrite;
      end else if (idx == IDX_MANUAL_ENABLE) begin
        rdata_d[BIT_SRC_LO +: SRC_N] = force_q;
      end else if (idx == IDX_HF_TRIM) begin
        rdata_d[TRIM_W-1:0] = trim_q;
      end else if (idx == IDX_HF_FREQ) begin
        rdata_d[FRQ_W-1:0] = frq_q;
      end else if (idx == IDX_SEC_POWER) begin
        rdata_d[0] = pwr_q;
      end else begin
        err_d = 1'b1;
      end
    end
    if (commit) begin
      if (idx == IDX_MANUAL_ENABLE) begin
        force_d = pwdata[BIT_SRC_LO +: SRC_N];
      end else if (idx == IDX_HF_TRIM) begin
        trim_d = pwdata[TRIM_W-1:0];
      end else if (idx == IDX_HF_FREQ) begin
        frq_d = pwdata[FRQ_W-1:0];
      end else if (idx == IDX_SEC_POWER) begin
        pwr_d = pwdata[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    en_d                  = force_q | req_or;
    ctrl_d.enable         = en_d;
    ctrl_d.sec_high_power = pwr_q;
    ctrl_d.trim           = trim_q;
    ctrl_d.freq_code      = frq_q;
    ctrl_d.freq_valid     = ((requested_source_select == SRC_HF_PLAIN) ||
                             (requested_source_select == SRC_HF_DOUBLED)) &&
                            freq_legal(requested_source_select, frq_q);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      force_q      <= ENABLE_RESET;
      trim_q       <= TRIM_RESET;
      frq_q        <= FRQ_RESET_PLAIN;
      pwr_q        <= SEC_POWER_RESET;
      strap_done_q <= 1'b0;
      en_q         <= '0;
      ctrl_q       <= '0;
      rdy_q        <= 1'b0;
      rdata_q      <= 32'h0000_0000;
      err_q        <= 1'b0;
    end else begin
      force_q      <= force_d;
      trim_q       <= trim_d;
      frq_q        <= frq_d;
      pwr_q        <= pwr_d;
      strap_done_q <= strap_done_d;
      en_q         <= en_d;
      ctrl_q       <= ctrl_d;
      rdy_q        <= rdy_d;
      rdata_q      <= rdata_d;
      err_q        <= err_d;
    end
  end

  assign pready     = rdy_q;
  assign prdata     = rdata_q;
  assign pslverr    = err_q;
  assign osc_enable = en_q;
  assign osc_ctrl   = ctrl_q;

endmodule : osc_ready_enable_tune_regs

/* design/osc_regs_pkg.sv */
// Package with register map, field positions and codes of the oscillator register block.
package osc_regs_pkg;
  // Printed offsets are not multiples of four: they are register indexes.
  localparam logic [11:0] IDX_READY_STATUS = 12'h890;
  localparam logic [11:0] IDX_MANUAL_ENABLE = 12'h891;
  localparam logic [11:0] IDX_HF_TRIM = 12'h892;
  localparam logic [11:0] IDX_HF_FREQ = 12'h893;
  localparam logic [11:0] IDX_SEC_POWER = 12'h894;
  localparam int ADDR_W = 14;
  localparam int SRC_N = 6;
  localparam int BIT_LOCK = 0;
  localparam int BIT_SRC_LO = 2;
  localparam int TRIM_W = 6;
  localparam int FRQ_W = 3;
  localparam logic [5:0] ENABLE_RESET = 6'h00;
  localparam logic [5:0] TRIM_RESET = 6'h00;
  localparam logic [5:0] TRIM_MAX = 6'h1F;
  localparam logic [5:0] TRIM_MIN = 6'h20;
  localparam logic [2:0] SRC_HF_PLAIN = 3'h6;
  localparam logic [2:0] SRC_HF_DOUBLED = 3'h1;
  localparam logic [2:0] FRQ_RESET_PLAIN = 3'h2;
  localparam logic [2:0] FRQ_RESET_DOUBLED = 3'h5;
  localparam logic [2:0] FRQ_RESERVED = 3'h7;
  localparam logic [2:0] FRQ_DBL_LO = 3'h3;
  localparam logic [2:0] FRQ_DBL_HI = 3'h5;
  localparam logic [0:0] SEC_POWER_RESET = 1'h0;

  // Source order of the enable and ready vectors, bit 0 upward.
  typedef enum logic [2:0] {
    SRC_ADC, SRC_SEC, SRC_LF, SRC_MF, SRC_HF, SRC_EXT
  } src_idx_t;

  typedef struct packed {
    logic [SRC_N-1:0] enable;
    logic             sec_high_power;
    logic [TRIM_W-1:0] trim;
    logic [FRQ_W-1:0] freq_code;
    logic             freq_valid;
  } osc_ctrl_t;

  // Legal frequency codes for the selected source column.
  function automatic logic freq_legal(input logic [2:0] sel, input logic [2:0] code);
    if (sel == SRC_HF_DOUBLED) begin
      freq_legal = (code >= FRQ_DBL_LO) && (code <= FRQ_DBL_HI);
    end else begin
      freq_legal = (code != FRQ_RESERVED);
    end
  endfunction : freq_legal
endpackage : osc_regs_pkg

/* test/osc_ready_enable_tune_regs_assertions.sv */
// Port assertions for the oscillator register block.
`timescale 1ns/1ns
module osc_regs_chk
  import osc_regs_pkg::*;
#(parameter int N_REQ = 4) (
  input wire logic                     clk, rst, psel, penable, pwrite,
  input wire logic [ADDR_W-1:0]        paddr,
  input wire logic                     pready, pslverr, lock_ready_raw,
  input wire logic [31:0]              prdata,
  input wire logic [2:0]               requested_source_select,
  input wire logic [N_REQ*SRC_N-1:0]   periph_request,
  input wire logic [SRC_N-1:0]         source_ready_raw, osc_enable,
  input wire osc_ctrl_t                osc_ctrl
);
  logic [SRC_N-1:0] req_or;
  always_comb begin
    req_or = '0;
    for (int j = 0; j < N_REQ; j++) req_or |= periph_request[j*SRC_N +: SRC_N];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  property p_ans; psel && penable && !pready |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("late answer");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_zero; !pready |-> prdata == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("stray read data");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_ro; pready && pwrite && paddr == 14'h2240 |-> pslverr; endproperty
  a_ro: assert property (p_ro) else $error("status accepted a write");
  // The flags pass two synchroniser flops and the read-data flop, so the status shows the input three samples back.
  property p_sts; pready && !pwrite && paddr == 14'h2240 |-> prdata[7:0] ==
    {$past(source_ready_raw, 3), 1'b0, $past(lock_ready_raw, 3)}; endproperty
  a_sts: assert property (p_sts) else $error("bad status bits");
  property p_req; 1 |=> (osc_enable & $past(req_or)) == $past(req_or); endproperty
  a_req: assert property (p_req) else $error("request lost");
  property p_val; osc_ctrl.freq_valid |->
    ($past(requested_source_select) == 3'h6 && osc_ctrl.freq_code != 3'h7) ||
    ($past(requested_source_select) == 3'h1 && osc_ctrl.freq_code inside {[3'h3:3'h5]});
  endproperty
  a_val: assert property (p_val) else $error("reserved code valid");
endmodule : osc_regs_chk
bind osc_ready_enable_tune_regs osc_regs_chk #(.N_REQ(N_REQ)) u_chk (.*);

/* test/tb_osc_ready_enable_tune_regs.sv */
// Self-checking bench of the oscillator register block.
`timescale 1ns/1ns
module tb_osc_ready_enable_tune_regs;
  import osc_regs_pkg::*;
  typedef struct packed {logic [13:0] a; logic [7:0] d, q; logic e;} row_t;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, lock_ready_raw = 0;
  logic pready, pslverr, er;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic [2:0] reset_source_config = 3'h6, requested_source_select = 3'h6;
  logic [4*SRC_N-1:0] periph_request = '0;
  logic [SRC_N-1:0] source_ready_raw = '0, osc_enable;
  osc_ctrl_t osc_ctrl;
  logic [2:0] sel [2] = '{3'h6, 3'h1};
  int fail_count = 0, total_checks = 0, cyc = 0;
  // Unused bits must read back zero, reserved codes are kept as written.
  row_t rows [10] = '{{14'h2244, 8'hFF, 8'hFC, 1'b0}, {14'h2248, 8'h1F, 8'h1F, 1'b0},
    {14'h2248, 8'h20, 8'h20, 1'b0}, {14'h2248, 8'hFF, 8'h3F, 1'b0},
    {14'h224C, 8'h06, 8'h06, 1'b0}, {14'h224C, 8'hFF, 8'h07, 1'b0},
    {14'h2250, 8'hFF, 8'h01, 1'b0}, {14'h2240, 8'hFF, 8'h00, 1'b1},
    {14'h2254, 8'hFF, 8'h00, 1'b1}, {14'h2241, 8'hFF, 8'h00, 1'b1}};
  osc_ready_enable_tune_regs dut (.*);
  initial forever #10 clk = ~clk;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Starts on an edge of its own, so a release is never overwritten in one step.
  task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge clk) penable <= 1;
    do @(negedge clk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    @(posedge clk);
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  always @(posedge clk) if (++cyc > 3000) begin fail_count++; summarize(); end
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    apb(14'h224C, 0, 0); chk(rd, 32'h2);
    apb(14'h2248, 0, 0); chk(rd, 32'h0);
    apb(14'h2244, 0, 0); chk(rd, 32'h0);
    source_ready_raw <= 6'h2A; lock_ready_raw <= 1;
    repeat (4) @(posedge clk);
    apb(14'h2240, 0, 0); chk(rd, 32'hA9);
    foreach (rows[i]) begin
      apb(rows[i].a, 1, 32'(rows[i].d)); chk(er, 32'(rows[i].e));
      if (!rows[i].e) begin apb(rows[i].a, 0, 0); chk(rd, rows[i].q); end
    end
    @(negedge clk); chk(osc_ctrl.sec_high_power, 32'h1);
    chk(osc_ctrl.trim, 32'h3F);
    @(posedge clk) periph_request <= 24'h800000;
    apb(14'h2244, 1, 32'h4);
    @(posedge clk);
    @(negedge clk); chk(osc_enable, 32'h21);
    chk(osc_ctrl.enable, 32'h21);
    foreach (sel[s]) begin
      @(posedge clk) requested_source_select <= sel[s];
      for (int c = 0; c < 8; c++) begin
        apb(14'h224C, 1, c);
        @(posedge clk);
        @(negedge clk);
        chk(osc_ctrl.freq_valid, sel[s] == 3'h6 ? c != 7 : c inside {[3:5]});
        chk(osc_ctrl.freq_code, c);
      end
    end
    @(posedge clk) rst <= 1;
    reset_source_config <= 3'h1;
    repeat (3) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    apb(14'h224C, 0, 0); chk(rd, 32'h5);
    apb(14'h2248, 0, 0); chk(rd, 32'h0);
    summarize();
  end
endmodule : tb_osc_ready_enable_tune_regs
